// [rtl/prc_pkg.sv]
// Package for the pSRAM refresh configuration register block
// Behaviour
// - Power-up value 0070h loaded into register
// - Bits 2:0 pick the refreshed array portion
// - Code 100 refreshes nothing
// - Codes 0xx bottom-anchored, 1xx top-anchored regions
// - 128Mb: 8M/4M/2M/1M words, top eighth 700000h
// - 64Mb region bounds per code
// - 32Mb region bounds per code
// - Bit 4 low: deep sleep, refresh stopped
// - Deep sleep loses array contents
// - 150us initialization after leaving deep sleep
// - Bits 6:5 select four refresh rates
// - Bit 7 enables asynchronous page mode
package prc_pkg;
  localparam logic [15:0] PRC_RESET_VAL = 16'h0070;
  localparam logic [15:0] PRC_WRITE_MASK = 16'h00F7;
  localparam int PRC_PAR_LSB = 0;
  localparam int PRC_SLEEP_BIT = 4;
  localparam int PRC_TEMP_LSB = 5;
  localparam int PRC_PAGE_BIT = 7;
  localparam int PRC_SEL_ADDR_BIT = 19;
  localparam int PRC_CLK_MHZ = 125;
  localparam int PRC_INIT_US = 150;
  localparam int PRC_INIT_CYCLES = PRC_INIT_US * PRC_CLK_MHZ;
  localparam logic [1:0] PRC_DENS_128 = 2'h0;
  localparam logic [1:0] PRC_DENS_64 = 2'h1;
  localparam logic [1:0] PRC_DENS_32 = 2'h2;
  localparam logic [2:0] PRC_PAR_NONE = 3'h4;
  // Temperature steps, ascending
  typedef enum logic [1:0] {PRC_T15, PRC_T45, PRC_T70, PRC_T85} prc_temp_t;
  typedef struct packed {
    logic [22:0] lo;
    logic [22:0] hi;
    logic active;
  } prc_region_t;
endpackage : prc_pkg

// [rtl/prc_refresh_cfg.sv]
// Refresh configuration register with refresh region decode
`timescale 1ns/100ps
`default_nettype none
module prc_refresh_cfg #(
  parameter int INIT_CYCLES = prc_pkg::PRC_INIT_CYCLES,
  parameter logic [1:0] DENSITY = prc_pkg::PRC_DENS_128
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic config_reg_enable,
  input wire logic we_n,
  input wire logic [22:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic refresh_enable,
  output logic deep_sleep,
  output logic init_busy,
  output logic array_valid,
  output logic page_mode_en,
  output prc_pkg::prc_temp_t temp_refresh_select,
  output prc_pkg::prc_region_t refresh_region
);
  logic [2:0] sync_cre_r;
  logic [1:0] sync_we_r;
  logic [22:0] sync_a0_r;
  logic [22:0] sync_a1_r;
  logic [15:0] sync_d0_r;
  logic [15:0] sync_d1_r;
  logic [15:0] refresh_config_reg_r;
  logic [31:0] init_cnt_r;
  logic wr_hit;

  // Two flops for every pin before use; third cre stage only for edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cre_r <= 3'h0;
      sync_we_r <= 2'h3;
      sync_a0_r <= 23'h000000;
      sync_a1_r <= 23'h000000;
      sync_d0_r <= 16'h0000;
      sync_d1_r <= 16'h0000;
    end else begin
      sync_cre_r <= {sync_cre_r[1:0], config_reg_enable};
      sync_we_r <= {sync_we_r[0], we_n};
      sync_a0_r <= addr;
      sync_a1_r <= sync_a0_r;
      sync_d0_r <= wdata;
      sync_d1_r <= sync_d0_r;
    end
  end

  // Write taken once per enable pulse, on its rising edge
  assign wr_hit = sync_cre_r[1] && !sync_cre_r[2] && !sync_we_r[1]
                  && !sync_a1_r[prc_pkg::PRC_SEL_ADDR_BIT];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_config_reg_r <= prc_pkg::PRC_RESET_VAL;
    end else if (wr_hit) begin
      // Undefined bits keep their power-up state
      refresh_config_reg_r <= (sync_d1_r & prc_pkg::PRC_WRITE_MASK)
                            | (prc_pkg::PRC_RESET_VAL & ~prc_pkg::PRC_WRITE_MASK);
    end
  end

  // Region bounds for each density and code
  function automatic prc_pkg::prc_region_t region_of(input logic [1:0] dens,
                                                     input logic [2:0] code);
    logic [22:0] top;
    logic [22:0] size;
    prc_pkg::prc_region_t r;
    top = (dens == prc_pkg::PRC_DENS_32) ? 23'h1FFFFF :
          (dens == prc_pkg::PRC_DENS_64) ? 23'h3FFFFF : 23'h7FFFFF;
    // 128Mb halves at each step; smaller dies keep 3/4, 1/2 and 1/4
    unique case (code[1:0])
      2'h0: size = top + 23'h000001;
      2'h1: size = (dens == prc_pkg::PRC_DENS_128) ? 23'h400000 :
                   (dens == prc_pkg::PRC_DENS_64) ? 23'h300000 : 23'h180000;
      2'h2: size = (dens == prc_pkg::PRC_DENS_128) ? (top >> 2) + 23'h000001
                                                   : (top >> 1) + 23'h000001;
      default: size = (dens == prc_pkg::PRC_DENS_128) ? (top >> 3) + 23'h000001
                                                      : (top >> 2) + 23'h000001;
    endcase
    r.active = (code != prc_pkg::PRC_PAR_NONE);
    if (!code[2]) begin
      r.lo = 23'h000000;
      r.hi = size - 23'h000001;
    end else begin
      r.lo = top - size + 23'h000001;
      r.hi = top;
    end
    if (!r.active) begin
      r.lo = 23'h000000;
      r.hi = 23'h000000;
    end
    return r;
  endfunction : region_of

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_region <= region_of(DENSITY, prc_pkg::PRC_RESET_VAL[2:0]);
    end else begin
      refresh_region <= region_of(DENSITY, refresh_config_reg_r[2:0]);
    end
  end

  // Exit from deep sleep starts the initialization timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_r <= 32'h00000000;
    end else if (!refresh_config_reg_r[prc_pkg::PRC_SLEEP_BIT]) begin
      init_cnt_r <= 32'(INIT_CYCLES);
    end else if (init_cnt_r != 32'h00000000) begin
      init_cnt_r <= init_cnt_r - 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep <= 1'b0;
      refresh_enable <= 1'b1;
      init_busy <= 1'b0;
    end else begin
      deep_sleep <= !refresh_config_reg_r[prc_pkg::PRC_SLEEP_BIT];
      refresh_enable <= refresh_config_reg_r[prc_pkg::PRC_SLEEP_BIT]
                        && refresh_config_reg_r[2:0] != prc_pkg::PRC_PAR_NONE;
      init_busy <= refresh_config_reg_r[prc_pkg::PRC_SLEEP_BIT]
                   && init_cnt_r > 32'h00000001;
    end
  end

  // Contents lost once deep sleep is seen; only a reset restores it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      array_valid <= 1'b1;
    end else if (!refresh_config_reg_r[prc_pkg::PRC_SLEEP_BIT]) begin
      array_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_mode_en <= 1'b0;
      temp_refresh_select <= prc_pkg::PRC_T85;
      rdata <= prc_pkg::PRC_RESET_VAL;
    end else begin
      page_mode_en <= refresh_config_reg_r[prc_pkg::PRC_PAGE_BIT];
      temp_refresh_select <= prc_pkg::prc_temp_t'(refresh_config_reg_r[6:5]);
      rdata <= refresh_config_reg_r;
    end
  end
endmodule : prc_refresh_cfg
`default_nettype wire

// [verif/prc_refresh_cfg_props.sv]
// Checker for the refresh configuration block
`timescale 1ns/100ps
`default_nettype none
module prc_refresh_cfg_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] rdata,
  input wire logic refresh_enable,
  input wire logic deep_sleep,
  input wire logic init_busy,
  input wire logic array_valid,
  input wire logic page_mode_en,
  input wire prc_pkg::prc_temp_t temp_refresh_select,
  input wire prc_pkg::prc_region_t refresh_region
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_sleep_bit: assert property (deep_sleep == !rdata[4]) else $error("sleep");
  a_page_bit: assert property (page_mode_en == rdata[7]) else $error("page");
  a_temp_field: assert property (temp_refresh_select == rdata[6:5]) else $error("temp");
  a_refresh_gate: assert property (refresh_enable == (rdata[4] && rdata[2:0] != 3'h4))
    else $error("gate");
  a_spare_bits: assert property (rdata[15:8] == 8'h00 && !rdata[3]) else $error("spare");
  a_bottom_anchor: assert property (refresh_enable && !rdata[2] |-> refresh_region.lo == 23'h0)
    else $error("anchor");
  a_data_loss: assert property ($rose(deep_sleep) |-> ##[0:1] !array_valid)
    else $error("loss");
  a_init_start: assert property ($fell(deep_sleep) |-> ##[0:1] init_busy)
    else $error("init");
  c_sleep: cover property ($rose(deep_sleep));
  c_init_done: cover property ($fell(init_busy));
  c_none: cover property (rdata[2:0] == 3'h4);
  c_page: cover property (page_mode_en);
endmodule : prc_refresh_cfg_props
bind prc_refresh_cfg prc_refresh_cfg_props prc_refresh_cfg_props_i (.*);
`default_nettype wire

// [verif/prc_host.sv]
// Host controller model driving the configuration pins
`timescale 1ns/100ps
`default_nettype none
module prc_host (
  input wire logic ref_clk,
  output logic config_reg_enable,
  output logic we_n,
  output logic [22:0] addr,
  output logic [15:0] wdata
);
  initial {config_reg_enable, we_n, addr, wdata} = {2'h1, 39'h0};
  // Pins settle three cycles ahead so the synchroniser sees them stable
  task automatic wr(input logic a19, input logic [15:0] d);
    @(negedge ref_clk);
    we_n = 1'b0;
    addr = {3'h0, a19, 19'h0};
    wdata = d;
    repeat (3) @(negedge ref_clk);
    config_reg_enable = 1'b1;
    repeat (6) @(negedge ref_clk);
    config_reg_enable = 1'b0;
    repeat (3) @(negedge ref_clk);
    we_n = 1'b1;
    wdata = ~d;
  endtask : wr
endmodule : prc_host
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench for the refresh configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic config_reg_enable, we_n, refresh_enable, deep_sleep, init_busy, array_valid, page_mode_en;
  logic [22:0] addr;
  logic [15:0] wdata, rdata, d;
  prc_pkg::prc_temp_t temp_refresh_select;
  prc_pkg::prc_region_t refresh_region, region_64, region_32;
  int mismatches = 0;
  int total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  prc_host prc_host_i (.*);
  prc_refresh_cfg #(.INIT_CYCLES(20)) prc_refresh_cfg_i (.*);
  prc_refresh_cfg #(.INIT_CYCLES(20), .DENSITY(prc_pkg::PRC_DENS_64)) prc_refresh_cfg_64_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .config_reg_enable(config_reg_enable), .we_n(we_n),
    .addr(addr), .wdata(wdata), .rdata(), .refresh_enable(), .deep_sleep(), .init_busy(),
    .array_valid(), .page_mode_en(), .temp_refresh_select(), .refresh_region(region_64));
  prc_refresh_cfg #(.INIT_CYCLES(20), .DENSITY(prc_pkg::PRC_DENS_32)) prc_refresh_cfg_32_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .config_reg_enable(config_reg_enable), .we_n(we_n),
    .addr(addr), .wdata(wdata), .rdata(), .refresh_enable(), .deep_sleep(), .init_busy(),
    .array_valid(), .page_mode_en(), .temp_refresh_select(), .refresh_region(region_32));
  // Region tables: 128Mb halves each step, smaller dies keep 3/4, 1/2, 1/4
  function automatic prc_pkg::prc_region_t exp_region(input int dens, input logic [2:0] c);
    logic [22:0] top;
    logic [22:0] s;
    top = 23'h7FFFFF >> dens;
    unique case (c[1:0])
      2'h0: s = top;
      2'h1: s = (dens == 0) ? top >> 1 : top - ((top + 23'h000001) >> 2);
      2'h2: s = (dens == 0) ? top >> 2 : top >> 1;
      default: s = (dens == 0) ? top >> 3 : top >> 2;
    endcase
    if (c[2]) return prc_pkg::prc_region_t'{top - s, top, 1'b1};
    else return prc_pkg::prc_region_t'{23'h000000, s, 1'b1};
  endfunction : exp_region
  task automatic chk(input string n, input logic [46:0] ex, input logic [46:0] s);
    total_checks++;
    if (s !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, ex, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'h8F68));
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("reset", {16'h0070, 4'hD}, {rdata, temp_refresh_select, page_mode_en, array_valid});
    chk("region0", exp_region(0, 3'h0), refresh_region);
    for (int c = 0; c < 8; c++) begin
      d = 16'($urandom) | 16'h0010;
      d[7:5] = {c[2], c[1:0]};
      d[2:0] = 3'(c);
      prc_host_i.wr(1'b0, d);
      chk("rdata", d & 16'h00F7, rdata);
      chk("gate", (c != 4), refresh_enable);
      if (c == 4) begin
        chk("none", 47'h0, refresh_region);
        chk("none64", 47'h0, region_64);
        chk("none32", 47'h0, region_32);
      end else begin
        chk("region", exp_region(0, 3'(c)), refresh_region);
        chk("region64", exp_region(1, 3'(c)), region_64);
        chk("region32", exp_region(2, 3'(c)), region_32);
      end
      chk("flags", d[7:5], {page_mode_en, temp_refresh_select});
    end
    prc_host_i.wr(1'b1, 16'h0000);
    chk("addr19", d & 16'h00F7, rdata);
    prc_host_i.wr(1'b0, 16'h0060);
    chk("sleep", 3'h4, {deep_sleep, array_valid, refresh_enable});
    prc_host_i.wr(1'b0, 16'h0070);
    chk("init", 2'h2, {init_busy, array_valid});
    for (int i = 0; i < 40 && init_busy !== 1'b0; i++) @(negedge ref_clk);
    chk("done", 1'b0, init_busy);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
